// [pci_host_register_access_pm_pkg.sv]
/*
 * Shared constants and carrier types for the PCI target register and power
 * management block. Assumes a decoded PCI target request port upstream.
 */
`default_nettype none
package pci_host_register_access_pm_pkg;

	// kinds of target access
	localparam logic [1:0] KIND_CFG = 2'h0;
	localparam logic [1:0] KIND_MEM = 2'h1;
	localparam logic [1:0] KIND_IO  = 2'h2;

	// configuration space byte offsets
	localparam logic [7:0] CFG_ID         = 8'h00;
	localparam logic [7:0] CFG_CMD_STAT   = 8'h04;
	localparam logic [7:0] CFG_CLASS      = 8'h08;
	localparam logic [7:0] CFG_HDR        = 8'h0c;
	localparam logic [7:0] CFG_IO_BAR     = 8'h10;
	localparam logic [7:0] CFG_MEM_BAR    = 8'h14;
	localparam logic [7:0] CFG_SUBSYS     = 8'h2c;
	localparam logic [7:0] CFG_CAP_PTR    = 8'h34;
	localparam logic [7:0] CFG_IRQ        = 8'h3c;
	localparam logic [7:0] CFG_PM_CAP     = 8'h40;
	localparam logic [7:0] CFG_PM_CSR     = 8'h44;
	localparam logic [7:0] CFG_WINDOW     = 8'h80;
	localparam logic [7:0] CFG_PMC_WR     = 8'he0;
	localparam logic [7:0] CFG_GNT_LAT_WR = 8'hfc;

	// reset and fixed values
	localparam logic [7:0]  IRQ_LINE_RST   = 8'hff;
	localparam logic [7:0]  IRQ_PIN_VAL    = 8'h01;
	localparam logic [7:0]  MIN_GNT_RST    = 8'h00;
	localparam logic [7:0]  MAX_LAT_RST    = 8'h10;
	localparam logic [7:0]  CAPABILITY_IDENTIFIER_VAL     = 8'h01;
	localparam logic [7:0]  CAP_NEXT_VAL   = 8'h00;
	localparam logic [15:0] PMC_RST        = 16'h7e21;
	localparam logic [15:0] STATUS_VAL     = 16'h0210;
	localparam logic [23:0] CLASS_VAL      = 24'h028000;
	localparam logic [7:0]  LATENCY_VAL    = 8'h10;
	localparam logic [7:0]  CAP_PTR_VAL    = 8'h40;
	localparam logic [15:0] CMD_WMASK      = 16'h0147;
	localparam logic [31:0] IO_BAR_MASK    = 32'hffff_fff8;
	localparam logic [31:0] MEM_BAR_MASK   = 32'hffff_ff00;
	localparam logic [31:0] WINDOW_MASK    = 32'hffff_8000;

	// field positions
	localparam int CMD_IO_EN     = 0;
	localparam int CMD_MEM_EN    = 1;
	localparam int CMD_MASTER_EN = 2;
	localparam int PM_FLAG_BIT   = 15;
	localparam int PM_ENABLE_BIT = 8;

	// power state field encodings
	localparam logic [1:0] PM_D0    = 2'h0;
	localparam logic [1:0] PM_D1    = 2'h1;
	localparam logic [1:0] PM_D2    = 2'h2;
	localparam logic [1:0] PM_D3HOT = 2'h3;

	// internal register offsets
	localparam logic [7:0] REG_LINE_STATE = 8'hc0;
	localparam logic [7:0] REG_LINE_CTRL  = 8'hc4;
	localparam logic [7:0] REG_LINE_CTRLE = 8'hc8;
	localparam logic [7:0] REG_BEARER_RX  = 8'hcc;
	localparam logic [7:0] REG_MULTIFRAME = 8'hd0;
	localparam logic [7:0] REG_DELAY      = 8'hdc;
	localparam logic [7:0] REG_BEARER1    = 8'hf0;
	localparam logic [7:0] REG_BEARER2    = 8'hf4;
	localparam logic [7:0] REG_SIGNAL     = 8'hf8;
	localparam logic [7:0] REG_ECHO       = 8'hfc;
	localparam logic [7:0] LINE_REG_RST   = 8'h00;

	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic        write;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} acc_req_t;

	typedef struct packed {
		logic [7:0]  min_gnt;
		logic [7:0]  max_lat;
		logic [15:0] power_capabilities;
	} eeprom_cfg_t;

	typedef struct packed {
		logic [7:0] bearer1;
		logic [7:0] bearer2;
		logic [7:0] signalling;
	} line_tx_t;

	typedef struct packed {
		logic [7:0] multiframe;
		logic [7:0] bearer1;
		logic [7:0] bearer2;
		logic [7:0] signalling;
		logic [7:0] echo;
	} line_rx_t;

	typedef struct packed {
		logic [7:0] line_state;
		logic [7:0] line_control;
		logic [7:0] line_control_extended;
		logic [7:0] bearer_receive_enable;
		logic [7:0] multiframe_send_bits;
		logic [7:0] line_delay_setup;
		line_tx_t   tx;
	} line_cfg_t;

endpackage : pci_host_register_access_pm_pkg
`default_nettype wire

// [line_register_file.sv]
/*
 * Internal line-section register file behind the target decoder.
 * Assumes one byte-wide access per cycle; read data is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module line_register_file
	import pci_host_register_access_pm_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       fifo_wr_i,
	input  wire line_tx_t   fifo_tx_i,
	input  wire line_rx_t   line_rx_i,
	output logic [7:0]      rdata_o,
	output line_cfg_t       cfg_o
);

	// one process owns the whole struct, so the output has a single driver
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_o.line_state            <= LINE_REG_RST;
			cfg_o.line_control          <= LINE_REG_RST;
			cfg_o.line_control_extended <= LINE_REG_RST;
			cfg_o.bearer_receive_enable <= LINE_REG_RST;
			cfg_o.multiframe_send_bits  <= LINE_REG_RST;
			cfg_o.line_delay_setup      <= LINE_REG_RST;
			cfg_o.tx                    <= '0;
		end else begin
			if (wr_i) begin
				case (addr_i)
					REG_LINE_STATE: cfg_o.line_state <= wdata_i;
					REG_LINE_CTRL:  cfg_o.line_control <= wdata_i;
					REG_LINE_CTRLE: cfg_o.line_control_extended <= wdata_i;
					REG_BEARER_RX:  cfg_o.bearer_receive_enable <= wdata_i;
					REG_MULTIFRAME: cfg_o.multiframe_send_bits <= wdata_i;
					REG_DELAY:      cfg_o.line_delay_setup <= wdata_i;
					REG_BEARER1:    cfg_o.tx.bearer1 <= wdata_i;
					REG_BEARER2:    cfg_o.tx.bearer2 <= wdata_i;
					REG_SIGNAL:     cfg_o.tx.signalling <= wdata_i;
					default: ;
				endcase
			end
			// fifo controller wins over software on a clash; software access is a debug path
			if (fifo_wr_i)
				cfg_o.tx <= fifo_tx_i;
		end
	end

	// write-only registers and unused offsets read as zero
	always_comb begin
		case (addr_i)
			REG_LINE_STATE: rdata_o = cfg_o.line_state;
			REG_MULTIFRAME: rdata_o = line_rx_i.multiframe;
			REG_BEARER1:    rdata_o = line_rx_i.bearer1;
			REG_BEARER2:    rdata_o = line_rx_i.bearer2;
			REG_SIGNAL:     rdata_o = line_rx_i.signalling;
			REG_ECHO:       rdata_o = line_rx_i.echo;
			default:        rdata_o = 8'h00;
		endcase
	end

endmodule : line_register_file
`default_nettype wire

// [pci_host_register_access_pm.sv]
/*
 * PCI target register access, configuration tail and power management.
 * Assumes an upstream PCI target that hands over one decoded access per
 * request and samples the registered answer on the following edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pci_host_register_access_pm
	import pci_host_register_access_pm_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = 16'h0a5a, // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h0c3c, // arbitrary value
	parameter logic [7:0]  REVISION    = 8'h00     // arbitrary value
) (
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire acc_req_t    req_i,
	output logic [31:0]      rdata_o,
	output logic             ack_o,
	input  wire logic        eeprom_load_i,
	input  wire eeprom_cfg_t eeprom_i,
	input  wire logic        wake_request_i,
	output logic             wake_event_o,
	output logic             master_enable_o,
	output logic [31:0]      window_base_o,
	output logic [7:0]       irq_line_o,
	output logic [7:0]       aux_addr_o,
	output logic [7:0]       aux_wdata_o,
	output logic             aux_wr_o,
	output logic             aux_rd_o,
	input  wire logic [7:0]  aux_rdata_i,
	input  wire logic        fifo_wr_i,
	input  wire line_tx_t    fifo_tx_i,
	input  wire line_rx_t    line_rx_i,
	output line_cfg_t        line_cfg_o
);

	logic [15:0] command;
	logic [31:0] io_bar;
	logic [31:0] mem_bar;
	logic [7:0]  min_gnt;
	logic [7:0]  max_lat;
	logic [15:0] power_capabilities;
	logic [1:0]  power_state_field;
	logic        wake_event_enable;
	logic        wake_event_flag;
	logic        window_valid;
	logic [7:0]  internal_register_number;

	logic        cfg_hit;
	logic        mem_hit;
	logic        io_hit;
	logic        cfg_wr;
	logic [7:0]  cfg_off;
	logic        io_upper;
	logic        int_wr;
	logic [7:0]  int_addr;
	logic [7:0]  int_rdata;
	logic [31:0] cfg_rdata;
	logic [31:0] next_rdata;
	logic        pm_clear;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		return (old & ~lanes) | (data & lanes);
	endfunction : merge

	// decode
	assign cfg_hit = req_i.valid && req_i.kind == KIND_CFG;
	assign cfg_wr  = cfg_hit && req_i.write;
	assign cfg_off = {req_i.addr[7:2], 2'b00};
	assign mem_hit = req_i.valid && req_i.kind == KIND_MEM && command[CMD_MEM_EN] &&
		req_i.addr[31:8] == mem_bar[31:8];
	assign io_hit  = req_i.valid && req_i.kind == KIND_IO && command[CMD_IO_EN] &&
		req_i.addr[31:3] == io_bar[31:3];
	assign io_upper = req_i.addr[2];

	// byte 0 reaches the selected register; byte 4 holds the selection
	always_comb begin
		int_addr = mem_hit ? req_i.addr[7:0] : internal_register_number;
		int_wr   = req_i.write && (mem_hit || (io_hit && !io_upper && req_i.be[0]));
	end

	line_register_file u_line_regs (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.wr_i      (int_wr),
		.addr_i    (int_addr),
		.wdata_i   (req_i.wdata[7:0]),
		.fifo_wr_i (fifo_wr_i),
		.fifo_tx_i (fifo_tx_i),
		.line_rx_i (line_rx_i),
		.rdata_o   (int_rdata),
		.cfg_o     (line_cfg_o)
	);

	// configuration header registers
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			command <= '0;
			io_bar  <= '0;
			mem_bar <= '0;
		end else if (cfg_wr) begin
			if (cfg_off == CFG_CMD_STAT)
				command <= 16'(merge({16'h0000, command}, req_i.wdata, req_i.be,
					{16'h0000, CMD_WMASK}));
			if (cfg_off == CFG_IO_BAR)
				io_bar <= merge(io_bar, req_i.wdata, req_i.be, IO_BAR_MASK);
			if (cfg_off == CFG_MEM_BAR)
				mem_bar <= merge(mem_bar, req_i.wdata, req_i.be, MEM_BAR_MASK);
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_line_o <= IRQ_LINE_RST;
		end else if (cfg_wr && cfg_off == CFG_IRQ && req_i.be[0]) begin
			irq_line_o <= req_i.wdata[7:0];
		end
	end

	// eeprom preload first, a configuration write in the same cycle overrides it
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			min_gnt <= MIN_GNT_RST;
			max_lat <= MAX_LAT_RST;
			power_capabilities     <= PMC_RST;
		end else begin
			if (cfg_wr && cfg_off == CFG_GNT_LAT_WR && req_i.be[2])
				min_gnt <= req_i.wdata[23:16];
			else if (eeprom_load_i)
				min_gnt <= eeprom_i.min_gnt;
			if (cfg_wr && cfg_off == CFG_GNT_LAT_WR && req_i.be[3])
				max_lat <= req_i.wdata[31:24];
			else if (eeprom_load_i)
				max_lat <= eeprom_i.max_lat;
			if (cfg_wr && cfg_off == CFG_PMC_WR && req_i.be[3:2] != 2'b00)
				power_capabilities <= 16'(merge({16'h0000, power_capabilities}, {16'h0000, req_i.wdata[31:16]},
					{2'b00, req_i.be[3:2]}, 32'h0000_ffff));
			else if (eeprom_load_i)
				power_capabilities <= eeprom_i.power_capabilities;
		end
	end

	// power management control/status
	assign pm_clear = cfg_wr && cfg_off == CFG_PM_CSR && req_i.be[1] &&
		req_i.wdata[PM_FLAG_BIT];

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			power_state_field <= PM_D0;
			wake_event_enable <= 1'b0;
		end else if (cfg_wr && cfg_off == CFG_PM_CSR) begin
			if (req_i.be[0])
				power_state_field <= req_i.wdata[1:0];
			if (req_i.be[1])
				wake_event_enable <= req_i.wdata[PM_ENABLE_BIT];
		end
	end

	// wake cause is honoured in every power state; a new cause beats a clear
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_event_flag <= 1'b0;
		end else if (wake_request_i) begin
			wake_event_flag <= 1'b1;
		end else if (pm_clear) begin
			wake_event_flag <= 1'b0;
		end
	end

	// limitation: the line-change wake cause is seen on this clock; a stopped
	// bus clock needs the cause held until the clock runs again
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_event_o <= 1'b0;
		end else begin
			wake_event_o <= (wake_event_flag || wake_request_i) && wake_event_enable;
		end
	end

	// window base: only a full dword write arms master mode
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			window_base_o <= '0;
			window_valid  <= 1'b0;
		end else if (cfg_wr && cfg_off == CFG_WINDOW && req_i.be == 4'hf) begin
			window_base_o <= req_i.wdata & WINDOW_MASK;
			window_valid  <= 1'b1;
		end
	end

	// fifo traffic relies on this; the host keeps to target control accesses
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			master_enable_o <= 1'b0;
		end else begin
			master_enable_o <= command[CMD_MASTER_EN] && power_state_field == PM_D0 &&
				window_valid;
		end
	end

	// I/O byte lanes: 0 data, 1 aux data, 3 aux address, 4 register select
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			internal_register_number <= '0;
			aux_addr_o  <= '0;
			aux_wdata_o <= '0;
			aux_wr_o    <= 1'b0;
			aux_rd_o    <= 1'b0;
		end else begin
			aux_wr_o <= io_hit && req_i.write && req_i.be[1];
			aux_rd_o <= io_hit && !req_i.write && req_i.be[1];
			if (io_hit && req_i.write) begin
				if (io_upper && req_i.be[0])
					internal_register_number <= req_i.wdata[7:0];
				if (req_i.be[1])
					aux_wdata_o <= req_i.wdata[15:8];
				if (req_i.be[3])
					aux_addr_o <= req_i.wdata[31:24];
			end
		end
	end

	// configuration read mux
	always_comb begin
		case (cfg_off)
			CFG_ID:       cfg_rdata = {DEVICE_CODE, VENDOR_CODE};
			CFG_CMD_STAT: cfg_rdata = {STATUS_VAL, command};
			CFG_CLASS:    cfg_rdata = {CLASS_VAL, REVISION};
			CFG_HDR:      cfg_rdata = {16'h0000, LATENCY_VAL, 8'h00};
			CFG_IO_BAR:   cfg_rdata = io_bar | 32'h0000_0001;
			CFG_MEM_BAR:  cfg_rdata = mem_bar;
			CFG_SUBSYS:   cfg_rdata = {DEVICE_CODE, VENDOR_CODE};
			CFG_CAP_PTR:  cfg_rdata = {24'h000000, CAP_PTR_VAL};
			CFG_IRQ:      cfg_rdata = {max_lat, min_gnt, IRQ_PIN_VAL, irq_line_o};
			CFG_PM_CAP:   cfg_rdata = {power_capabilities, CAP_NEXT_VAL, CAPABILITY_IDENTIFIER_VAL};
			CFG_PM_CSR:   cfg_rdata = {16'h0000, wake_event_flag, 6'h00, wake_event_enable,
				6'h00, power_state_field};
			CFG_WINDOW:   cfg_rdata = window_base_o;
			default:      cfg_rdata = 32'h0000_0000;
		endcase
	end

	always_comb begin
		if (cfg_hit)
			next_rdata = cfg_rdata;
		else if (mem_hit)
			next_rdata = {24'h000000, int_rdata};
		else if (io_hit && io_upper)
			next_rdata = {aux_addr_o, 8'h00, aux_rdata_i, internal_register_number};
		else if (io_hit)
			next_rdata = {aux_addr_o, 8'h00, aux_rdata_i, int_rdata};
		else
			next_rdata = 32'h0000_0000;
	end

	// unclaimed accesses get no answer and fall to master abort upstream
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o   <= 1'b0;
			rdata_o <= '0;
		end else begin
			ack_o   <= cfg_hit || mem_hit || io_hit;
			rdata_o <= req_i.write ? 32'h0000_0000 : next_rdata;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_master_off_d0: assert property (
		power_state_field != PM_D0 |=> !master_enable_o)
		else $error("master enabled outside D0");
	a_master_cmd_bit: assert property (
		!command[CMD_MASTER_EN] |=> !master_enable_o)
		else $error("master enabled with command bit clear");
	a_master_armed: assert property (
		master_enable_o |-> window_valid && $past(window_valid))
		else $error("master enabled before window write");
	a_wake_gate: assert property (
		!wake_event_enable |=> !wake_event_o)
		else $error("wake event driven while disabled");
	a_wake_sticky: assert property (
		wake_request_i |=> wake_event_flag [*2] or
			(wake_event_flag ##1 $past(pm_clear) && !$past(wake_request_i)))
		else $error("wake flag not set by cause");
	a_wake_zero_write: assert property (
		wake_event_flag && !pm_clear |=> wake_event_flag)
		else $error("wake flag lost without a one written");
	a_wake_clear: assert property (
		pm_clear && !wake_request_i |=> !wake_event_flag)
		else $error("wake flag not cleared by one");
	a_unimpl_zero: assert property (
		cfg_hit && !req_i.write && cfg_off == 8'h30 |=> ack_o && rdata_o == 32'h0000_0000)
		else $error("unimplemented config register not zero");
	a_cap_ident: assert property (
		cfg_hit && !req_i.write && cfg_off == CFG_PM_CAP |=>
			rdata_o[15:0] == {CAP_NEXT_VAL, CAPABILITY_IDENTIFIER_VAL})
		else $error("capability identifier wrong");
	a_pm_reserved: assert property (
		cfg_hit && !req_i.write && cfg_off == CFG_PM_CSR |=>
			rdata_o[14:9] == 6'h00 && rdata_o[7:2] == 6'h00 && rdata_o[1:0] == $past(power_state_field))
		else $error("power control word reserved bits set");
	a_window_low: assert property (
		window_base_o[14:0] == 15'h0000)
		else $error("window base low bits set");
	a_io_select: assert property (
		io_hit && req_i.write && io_upper && req_i.be[0] |=>
			internal_register_number == $past(req_i.wdata[7:0]))
		else $error("register select not latched");
	a_aux_write: assert property (
		io_hit && req_i.write && req_i.be[1] |=> aux_wr_o && aux_wdata_o == $past(req_i.wdata[15:8]))
		else $error("aux data write lost");
	a_wake_set_wins: assert property (
		wake_request_i && pm_clear |=> wake_event_flag)
		else $error("wake flag cleared despite new cause");
	a_window_partial: assert property (
		cfg_wr && cfg_off == CFG_WINDOW && req_i.be != 4'hf |=> $stable(window_base_o))
		else $error("window base changed by partial write");

	c_io_indirect: cover property (
		io_hit && req_i.write && io_upper ##[1:8] io_hit && !io_upper && req_i.be[0]);
	c_master_on: cover property (!master_enable_o ##1 master_enable_o);
	c_wake_driven: cover property (wake_request_i ##[1:4] wake_event_o);
	c_set_beats_clear: cover property (wake_request_i && pm_clear);

endmodule : pci_host_register_access_pm
`default_nettype wire

// [line_aux_model.sv]
/* far-side model: aux port peripheral and line receive levels.
 * assumes aux read data is taken combinationally in the request cycle. */
`timescale 1ns/1ps
`default_nettype none
module line_aux_model
	import pci_host_register_access_pm_pkg::*;
(
	input  wire logic [7:0] aux_addr_i,
	output logic [7:0]      aux_rdata_o,
	output line_rx_t        line_rx_o
);
	// data tied to the address, so a stale or wrong address shows up
	assign aux_rdata_o = aux_addr_i ^ 8'h5c;
	assign line_rx_o = 40'h11_2233_4455;
endmodule : line_aux_model
`default_nettype wire

// [tb_top.sv]
/* self-checking bench: sequences of target reads and writes.
 * assumes the one-cycle registered answer of the target port. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pci_host_register_access_pm_pkg::*;
;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	acc_req_t    req_i;
	logic [31:0] rdata_o, window_base_o;
	logic        ack_o, eeprom_load_i, wake_request_i, wake_event_o;
	logic        master_enable_o, aux_wr_o, aux_rd_o, fifo_wr_i;
	logic [7:0]  irq_line_o, aux_addr_o, aux_wdata_o, aux_rdata_i;
	eeprom_cfg_t eeprom_i;
	line_tx_t    fifo_tx_i;
	line_rx_t    line_rx_i;
	line_cfg_t   line_cfg_o;
	int          errors = 0;
	int          num_checks = 0;
	int          aux_writes = 0;
	int          aux_reads = 0;
	logic [31:0] wo[4] = '{32'hc4, 32'hc8, 32'hcc, 32'hdc};
	localparam logic [31:0] IOB = 32'h1000;
	localparam logic [31:0] MEMB = 32'h2000;

	pci_host_register_access_pm u_pci_host_register_access_pm (
		.mclk_i, .nrst_i, .req_i, .rdata_o, .ack_o, .eeprom_load_i, .eeprom_i,
		.wake_request_i, .wake_event_o, .master_enable_o, .window_base_o,
		.irq_line_o, .aux_addr_o, .aux_wdata_o, .aux_wr_o, .aux_rd_o,
		.aux_rdata_i, .fifo_wr_i, .fifo_tx_i, .line_rx_i, .line_cfg_o
	);
	line_aux_model u_line_aux_model (
		.aux_addr_i(aux_addr_o), .aux_rdata_o(aux_rdata_i), .line_rx_o(line_rx_i)
	);

	always #2.5 mclk_i = ~mclk_i;

	// pulses counted mid-cycle, clear of the launching edge
	always @(negedge mclk_i) begin
		if (aux_wr_o === 1'b1)
			aux_writes++;
		if (aux_rd_o === 1'b1)
			aux_reads++;
	end

	task summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cyc

	// one request, answer looked at in the cycle after the taking edge
	task acc(input logic [1:0] k, input logic w, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic [31:0] m, input logic [31:0] e, input logic c);
		req_i = '{1'b1, k, w, a, b, d};
		@(posedge mclk_i);
		#1 req_i.valid = 1'b0;
		chk({31'h0, ack_o}, {31'h0, c});
		chk(rdata_o & m, e);
		cyc(1);
	endtask : acc

	task wr(input logic [1:0] k, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] d);
		acc(k, 1'b1, a, b, d, '1, '0, 1'b1);
	endtask : wr

	task rd(input logic [1:0] k, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] m, input logic [31:0] e);
		acc(k, 1'b0, a, b, '0, m, e, 1'b1);
	endtask : rd

	task wake_pulse;
		wake_request_i = 1'b1;
		cyc(1);
		wake_request_i = 1'b0;
		cyc(2);
	endtask : wake_pulse

	initial begin
		req_i = '0;
		eeprom_load_i = 1'b0;
		eeprom_i = '{8'h44, 8'h55, 16'h6789};
		wake_request_i = 1'b0;
		fifo_wr_i = 1'b0;
		fifo_tx_i = 24'hb1b2b3;
		cyc(12);
		chk({24'h0, irq_line_o}, {24'h0, IRQ_LINE_RST});
		nrst_i = 1'b1;
		rd(KIND_CFG, 32'h3c, 4'hf, '1, {MAX_LAT_RST, MIN_GNT_RST, IRQ_PIN_VAL, IRQ_LINE_RST});
		rd(KIND_CFG, 32'h40, 4'hf, '1, {PMC_RST, CAP_NEXT_VAL, CAPABILITY_IDENTIFIER_VAL});
		rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h0);
		rd(KIND_CFG, 32'h80, 4'hf, '1, 32'h0);
		rd(KIND_CFG, 32'h50, 4'hf, '1, 32'h0);
		rd(KIND_CFG, 32'h30, 4'hf, '1, 32'h0);
		wr(KIND_CFG, 32'h3c, 4'hf, 32'hffff_ff0a);
		chk({24'h0, irq_line_o}, 32'h0a);
		wr(KIND_CFG, 32'hfc, 4'hc, 32'h2233_0000);
		rd(KIND_CFG, 32'h3c, 4'hf, '1, 32'h2233_010a);
		wr(KIND_CFG, 32'he0, 4'hc, 32'h1234_0000);
		rd(KIND_CFG, 32'h40, 4'hf, '1, 32'h1234_0001);
		eeprom_load_i = 1'b1;
		cyc(1);
		eeprom_load_i = 1'b0;
		rd(KIND_CFG, 32'h3c, 4'hf, '1, 32'h5544_010a);
		rd(KIND_CFG, 32'h40, 4'hf, '1, 32'h6789_0001);
		for (int s = 0; s < 4; s++) begin
			wr(KIND_CFG, 32'h44, 4'h3, 32'h8100 | s);
			wake_pulse();
			chk({31'h0, wake_event_o}, 32'h1);
			rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h8100 | s);
		end
		wr(KIND_CFG, 32'h44, 4'h3, 32'h7fff);
		rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h8103);
		wr(KIND_CFG, 32'h44, 4'h3, 32'h8000);
		chk({31'h0, wake_event_o}, 32'h0);
		wake_pulse();
		chk({31'h0, wake_event_o}, 32'h0);
		rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h8000);
		wake_request_i = 1'b1;
		wr(KIND_CFG, 32'h44, 4'h3, 32'h8000);
		wake_request_i = 1'b0;
		rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h8000);
		wr(KIND_CFG, 32'h44, 4'h3, 32'h8000);
		rd(KIND_CFG, 32'h44, 4'hf, '1, 32'h0000);
		wr(KIND_CFG, 32'h04, 4'h1, 32'h7);
		wr(KIND_CFG, 32'h10, 4'hf, IOB);
		wr(KIND_CFG, 32'h14, 4'hf, MEMB);
		wr(KIND_CFG, 32'h80, 4'h3, '1);
		rd(KIND_CFG, 32'h80, 4'hf, '1, 32'h0);
		chk({31'h0, master_enable_o}, 32'h0);
		wr(KIND_CFG, 32'h80, 4'hf, '1);
		rd(KIND_CFG, 32'h80, 4'hf, '1, 32'hffff_8000);
		chk(window_base_o, 32'hffff_8000);
		chk({31'h0, master_enable_o}, 32'h1);
		wr(KIND_CFG, 32'h44, 4'h3, 32'h2);
		chk({31'h0, master_enable_o}, 32'h0);
		wr(KIND_CFG, 32'h44, 4'h3, 32'h0);
		wr(KIND_CFG, 32'h04, 4'h1, 32'h3);
		chk({31'h0, master_enable_o}, 32'h0);
		wr(KIND_MEM, MEMB | 32'hc0, 4'h1, 32'h5a);
		rd(KIND_MEM, MEMB | 32'hc0, 4'h1, 32'hff, 32'h5a);
		acc(KIND_MEM, 1'b0, 32'h30c0, 4'h1, '0, '1, '0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(KIND_MEM, MEMB | wo[i], 4'h1, wo[i]);
			rd(KIND_MEM, MEMB | wo[i], 4'h1, '1, 32'h0);
		end
		chk({line_cfg_o.line_control, line_cfg_o.line_control_extended,
			line_cfg_o.bearer_receive_enable, line_cfg_o.line_delay_setup}, 32'hc4c8_ccdc);
		rd(KIND_MEM, MEMB | 32'hd0, 4'h1, 32'hff, 32'h11);
		wr(KIND_MEM, MEMB | 32'hd0, 4'h1, 32'h6d);
		chk({24'h0, line_cfg_o.multiframe_send_bits}, 32'h6d);
		for (int i = 0; i < 4; i++) begin
			rd(KIND_MEM, MEMB | (32'hf0 + 4 * i), 4'h1, 32'hff, 32'h22 + 32'h11 * i);
		end
		wr(KIND_MEM, MEMB | 32'hfc, 4'h1, 32'h99);
		rd(KIND_MEM, MEMB | 32'hfc, 4'h1, 32'hff, 32'h55);
		wr(KIND_MEM, MEMB | 32'hf0, 4'h1, 32'ha1);
		chk({24'h0, line_cfg_o.tx.bearer1}, 32'ha1);
		fifo_wr_i = 1'b1;
		cyc(1);
		fifo_wr_i = 1'b0;
		cyc(1);
		chk({8'h0, line_cfg_o.tx}, 32'hb1b2b3);
		wr(KIND_IO, IOB + 32'h4, 4'h1, 32'hc0);
		rd(KIND_IO, IOB + 32'h4, 4'h1, 32'hff, 32'hc0);
		rd(KIND_IO, IOB, 4'h1, 32'hff, 32'h5a);
		wr(KIND_IO, IOB, 4'h8, 32'h7700_0000);
		chk({24'h0, aux_addr_o}, 32'h77);
		rd(KIND_IO, IOB, 4'h2, 32'hff00, 32'h2b00);
		wr(KIND_IO, IOB + 32'h4, 4'h2, 32'h9900);
		chk({24'h0, aux_wdata_o}, 32'h99);
		acc(KIND_IO, 1'b0, IOB + 32'h8, 4'h1, '0, '1, '0, 1'b0);
		chk(aux_writes, 32'd1);
		chk(aux_reads, 32'd1);
		summarize();
	end

	// a hung run still reaches the report
	initial begin
		repeat (5000) @(posedge mclk_i);
		errors++;
		$display("wrong value at %0t: run did not finish", $time);
		summarize();
	end
endmodule : tb_top
`default_nettype wire
